// >>> hw/fdrl_pkg.sv
package fdrl_pkg;

  // register bus geometry
  localparam int         FDRL_ADDR_W        = 8;
  localparam int         FDRL_IDX_W         = 6;
  localparam int         FDRL_DATA_W        = 32;
  localparam int         FDRL_CH            = 4;

  // register indices, byte address is four times the index
  localparam logic [5:0] FDRL_IDX_DYN_CTRL  = 6'h0B;
  localparam logic [5:0] FDRL_IDX_AC12      = 6'h1A;
  localparam logic [5:0] FDRL_IDX_AC34      = 6'h1B;
  localparam logic [5:0] FDRL_IDX_OUT_CFG1  = 6'h21;
  localparam logic [5:0] FDRL_IDX_OUT_CFG2  = 6'h22;
  localparam logic [5:0] FDRL_IDX_OUT_CFG3  = 6'h23;
  localparam logic [5:0] FDRL_IDX_OUT_CFG4  = 6'h24;
  localparam logic [5:0] FDRL_IDX_OP_PT1    = 6'h30;
  localparam logic [5:0] FDRL_IDX_OP_PT2    = 6'h31;
  localparam logic [5:0] FDRL_IDX_OP_PT3    = 6'h32;
  localparam logic [5:0] FDRL_IDX_OP_PT4    = 6'h33;

  // field positions
  localparam int         FDRL_CAP_EN_LSB    = 2;
  localparam int         FDRL_EN_ODD        = 0;
  localparam int         FDRL_EN_EVEN       = 1;
  localparam int         FDRL_STEP_ODD_LSB  = 2;
  localparam int         FDRL_STEP_EVEN_LSB = 5;
  localparam int         FDRL_STEP_W        = 3;
  localparam int         FDRL_SLOW_BIT      = 3;

  // values
  localparam logic [7:0] FDRL_REG_RST       = 8'h00;
  localparam logic [7:0] FDRL_DUTY_RST      = 8'h00;
  localparam logic [7:0] FDRL_DUTY_MAX      = 8'hFF;
  localparam logic [1:0] FDRL_SLOW_LAST     = 2'h3;
  localparam logic [1:0] FDRL_SLOW_RST      = 2'h0;
  localparam logic [1:0] FDRL_RESP_OKAY     = 2'h0;
  localparam logic [1:0] FDRL_RESP_SLVERR   = 2'h2;
  localparam logic [23:0] FDRL_RD_PAD       = 24'h000000;

  // step size in slots for a step-select code
  function automatic logic [7:0] fdrl_step_size(input logic [2:0] code);
    case (code)
      3'h0:    fdrl_step_size = 8'h01;
      3'h1:    fdrl_step_size = 8'h02;
      3'h2:    fdrl_step_size = 8'h03;
      3'h3:    fdrl_step_size = 8'h05;
      3'h4:    fdrl_step_size = 8'h08;
      3'h5:    fdrl_step_size = 8'h0C;
      3'h6:    fdrl_step_size = 8'h18;
      default: fdrl_step_size = 8'h30;
    endcase
  endfunction

endpackage

// >>> hw/fdrl_slew.sv
`timescale 1ns/1ps
module fdrl_slew
  import fdrl_pkg::*;
(
  input  wire logic [7:0] prev_duty,
  input  wire logic [7:0] target_duty,
  input  wire logic       smooth_en,
  input  wire logic [2:0] step_sel,
  output logic      [7:0] next_duty
);

  logic [7:0] step;
  logic [7:0] gap;

  always_comb begin
    step = fdrl_step_size(step_sel); // RL9 RL13
    gap  = FDRL_REG_RST;
    if (!smooth_en) begin
      next_duty = target_duty; // RL3
    end else if (target_duty > prev_duty) begin // RL10
      gap = target_duty - prev_duty;
      // never past the target, so never beyond full scale
      next_duty = (gap > step) ? prev_duty + step : target_duty; // RL4 RL11 RL16
    end else if (target_duty < prev_duty) begin
      gap = prev_duty - target_duty;
      next_duty = (gap > step) ? prev_duty - step : target_duty; // RL4 RL11 RL16
    end else begin
      next_duty = prev_duty; // RL16
    end
  end

endmodule

// >>> hw/fdrl_top.sv
// What this block does
// RL1: capture enable set and alarm asserted copies remote temperature into operating point.
// RL2: capture enable clear means alarms ignored, operating point keeps software value.
// RL3: smoothing off applies the new automatic duty at once.
// RL4: smoothing on limits each update's duty change to the chosen step.
// RL5: first acoustic register bit 0 enables output 1, bit 1 output 2.
// RL6: second acoustic register bit 0 enables output 3, bit 1 output 4.
// RL7: each output ramps on its own, with its own enable and step.
// RL8: duty is counted in slots, 255 to a full period.
// RL9: step is one of 1, 2, 3, 5, 8, 12, 24 or 48 slots.
// RL10: each update compares the new target with the stored previous duty.
// RL11: target above raises by the step, target below lowers by the step.
// RL12: the result is stored as previous duty and driven out.
// RL13: bits 4:2 pick the odd output step, bits 7:5 the even one.
// RL14: slow bit 3 of an output config register cuts ramp rate by four.
// RL15: the external processor asserts the alarm by driving it low.
// RL16: equal target leaves duty alone; a step never overshoots or leaves 0..255.
// RL17: reset clears smoothing enables and previous duties.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fdrl_top
  import fdrl_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  input  wire logic [FDRL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [FDRL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   thermal_alarm_n,
  input  wire logic [7:0]             remote_temp_1,
  input  wire logic [7:0]             remote_temp_2,
  input  wire logic [7:0]             remote_temp_3,
  input  wire logic [7:0]             remote_temp_4,
  input  wire logic                   duty_update,
  input  wire logic [7:0]             target_duty_1,
  input  wire logic [7:0]             target_duty_2,
  input  wire logic [7:0]             target_duty_3,
  input  wire logic [7:0]             target_duty_4,
  output logic [7:0]                  duty_out_1,
  output logic [7:0]                  duty_out_2,
  output logic [7:0]                  duty_out_3,
  output logic [7:0]                  duty_out_4
);

  typedef struct packed {
    logic                        aw_got;
    logic [FDRL_IDX_W-1:0]       aw_idx;
    logic                        w_got;
    logic [7:0]                  w_data;
    logic                        w_lane0;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic [7:0]                  dyn_ctrl;
    logic [7:0]                  ac12;
    logic [7:0]                  ac34;
    logic [FDRL_CH-1:0][7:0]     out_cfg;
    logic [FDRL_CH-1:0][7:0]     op_point;
    logic                        alarm_prev;
    logic [FDRL_CH-1:0][1:0]     slow_cnt;
    logic [FDRL_CH-1:0][7:0]     duty;
  } fdrl_state_t;

  fdrl_state_t state_r;
  fdrl_state_t state_nxt;

  logic [FDRL_CH-1:0][7:0] remote_temp;
  logic [FDRL_CH-1:0][7:0] target_duty;
  logic [FDRL_CH-1:0]      smooth_en;
  logic [FDRL_CH-1:0][2:0] step_sel;
  logic [FDRL_CH-1:0][7:0] slew_next;

  assign remote_temp[0] = remote_temp_1;
  assign remote_temp[1] = remote_temp_2;
  assign remote_temp[2] = remote_temp_3;
  assign remote_temp[3] = remote_temp_4;
  assign target_duty[0] = target_duty_1;
  assign target_duty[1] = target_duty_2;
  assign target_duty[2] = target_duty_3;
  assign target_duty[3] = target_duty_4;

  // per-output enables and step codes
  assign smooth_en[0] = state_r.ac12[FDRL_EN_ODD]; // RL5
  assign smooth_en[1] = state_r.ac12[FDRL_EN_EVEN]; // RL5
  assign smooth_en[2] = state_r.ac34[FDRL_EN_ODD]; // RL6
  assign smooth_en[3] = state_r.ac34[FDRL_EN_EVEN]; // RL6
  assign step_sel[0]  = state_r.ac12[FDRL_STEP_ODD_LSB +: FDRL_STEP_W]; // RL13
  assign step_sel[1]  = state_r.ac12[FDRL_STEP_EVEN_LSB +: FDRL_STEP_W]; // RL13
  assign step_sel[2]  = state_r.ac34[FDRL_STEP_ODD_LSB +: FDRL_STEP_W]; // RL13
  assign step_sel[3]  = state_r.ac34[FDRL_STEP_EVEN_LSB +: FDRL_STEP_W]; // RL13

  // one slew limiter per output
  for (genvar k = 0; k < FDRL_CH; k++) begin : g_slew
    fdrl_slew u_slew (
      .prev_duty   (state_r.duty[k]),
      .target_duty (target_duty[k]),
      .smooth_en   (smooth_en[k]),
      .step_sel    (step_sel[k]),
      .next_duty   (slew_next[k])
    ); // RL7
  end

  // register index of a byte address
  function automatic logic [FDRL_IDX_W-1:0] reg_idx(input logic [FDRL_ADDR_W-1:0] addr);
    reg_idx = addr[FDRL_ADDR_W-1:2];
  endfunction

  // readback of a register index, ok is low for unmapped
  function automatic logic [8:0] reg_read(input logic [FDRL_IDX_W-1:0] idx,
                                          input fdrl_state_t            s);
    case (idx)
      FDRL_IDX_DYN_CTRL: reg_read = {1'b1, s.dyn_ctrl};
      FDRL_IDX_AC12:     reg_read = {1'b1, s.ac12};
      FDRL_IDX_AC34:     reg_read = {1'b1, s.ac34};
      FDRL_IDX_OUT_CFG1: reg_read = {1'b1, s.out_cfg[0]};
      FDRL_IDX_OUT_CFG2: reg_read = {1'b1, s.out_cfg[1]};
      FDRL_IDX_OUT_CFG3: reg_read = {1'b1, s.out_cfg[2]};
      FDRL_IDX_OUT_CFG4: reg_read = {1'b1, s.out_cfg[3]};
      FDRL_IDX_OP_PT1:   reg_read = {1'b1, s.op_point[0]};
      FDRL_IDX_OP_PT2:   reg_read = {1'b1, s.op_point[1]};
      FDRL_IDX_OP_PT3:   reg_read = {1'b1, s.op_point[2]};
      FDRL_IDX_OP_PT4:   reg_read = {1'b1, s.op_point[3]};
      default:           reg_read = {1'b0, FDRL_REG_RST};
    endcase
  endfunction

  // write-side decode, ok is low for unmapped
  function automatic logic reg_mapped(input logic [FDRL_IDX_W-1:0] idx);
    logic [8:0] probe;
    probe = reg_read(idx, state_r);
    reg_mapped = probe[8];
  endfunction

  logic [8:0] rd_word;
  logic       do_write;
  logic       alarm_fall;
  logic       apply;

  always_comb begin
    state_nxt  = state_r;
    rd_word    = {1'b0, FDRL_REG_RST};
    do_write   = 1'b0;
    alarm_fall = 1'b0;
    apply      = 1'b0;

    // write address and data taken in either order
    if (s_axi_awvalid && state_r.awready) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.aw_idx = reg_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && state_r.wready) begin
      state_nxt.w_got   = 1'b1;
      state_nxt.w_data  = s_axi_wdata[7:0];
      state_nxt.w_lane0 = s_axi_wstrb[0];
    end

    // response retires first
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end

    if (state_nxt.aw_got && state_nxt.w_got && !state_nxt.bvalid) begin
      do_write         = 1'b1;
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got  = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp  = reg_mapped(state_nxt.aw_idx) ? FDRL_RESP_OKAY : FDRL_RESP_SLVERR;
    end

    if (do_write && state_nxt.w_lane0) begin
      case (state_nxt.aw_idx)
        FDRL_IDX_DYN_CTRL: state_nxt.dyn_ctrl    = state_nxt.w_data;
        FDRL_IDX_AC12:     state_nxt.ac12        = state_nxt.w_data;
        FDRL_IDX_AC34:     state_nxt.ac34        = state_nxt.w_data;
        FDRL_IDX_OUT_CFG1: state_nxt.out_cfg[0]  = state_nxt.w_data;
        FDRL_IDX_OUT_CFG2: state_nxt.out_cfg[1]  = state_nxt.w_data;
        FDRL_IDX_OUT_CFG3: state_nxt.out_cfg[2]  = state_nxt.w_data;
        FDRL_IDX_OUT_CFG4: state_nxt.out_cfg[3]  = state_nxt.w_data;
        FDRL_IDX_OP_PT1:   state_nxt.op_point[0] = state_nxt.w_data;
        FDRL_IDX_OP_PT2:   state_nxt.op_point[1] = state_nxt.w_data;
        FDRL_IDX_OP_PT3:   state_nxt.op_point[2] = state_nxt.w_data;
        FDRL_IDX_OP_PT4:   state_nxt.op_point[3] = state_nxt.w_data;
        default: begin
        end
      endcase
    end

    state_nxt.awready = !state_nxt.aw_got && !state_nxt.bvalid;
    state_nxt.wready  = !state_nxt.w_got && !state_nxt.bvalid;

    // read channel
    if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_r.arready) begin
      rd_word          = reg_read(reg_idx(s_axi_araddr), state_r);
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata  = {FDRL_RD_PAD, rd_word[7:0]};
      state_nxt.rresp  = rd_word[8] ? FDRL_RESP_OKAY : FDRL_RESP_SLVERR;
    end
    state_nxt.arready = !state_nxt.rvalid;

    // alarm assertion is its high-to-low transition
    alarm_fall           = state_r.alarm_prev && !thermal_alarm_n; // RL15
    state_nxt.alarm_prev = thermal_alarm_n;

    for (int k = 0; k < FDRL_CH; k++) begin
      // capture wins over a same-cycle software write
      if (alarm_fall && state_r.dyn_ctrl[FDRL_CAP_EN_LSB + k]) begin
        state_nxt.op_point[k] = remote_temp[k]; // RL1
      end // RL2

      if (duty_update) begin
        state_nxt.slow_cnt[k] = state_r.slow_cnt[k] + 2'h1;
        apply = !smooth_en[k]
             || !state_r.out_cfg[k][FDRL_SLOW_BIT]
             || (state_r.slow_cnt[k] == FDRL_SLOW_LAST); // RL14
        if (apply) begin
          state_nxt.duty[k] = slew_next[k]; // RL8 RL12
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r.aw_got     <= 1'b0;
      state_r.aw_idx     <= '0;
      state_r.w_got      <= 1'b0;
      state_r.w_data     <= FDRL_REG_RST;
      state_r.w_lane0    <= 1'b0;
      state_r.awready    <= 1'b1;
      state_r.wready     <= 1'b1;
      state_r.bvalid     <= 1'b0;
      state_r.bresp      <= FDRL_RESP_OKAY;
      state_r.arready    <= 1'b1;
      state_r.rvalid     <= 1'b0;
      state_r.rresp      <= FDRL_RESP_OKAY;
      state_r.rdata      <= '0;
      state_r.dyn_ctrl   <= FDRL_REG_RST;
      state_r.ac12       <= FDRL_REG_RST; // RL17
      state_r.ac34       <= FDRL_REG_RST; // RL17
      state_r.out_cfg    <= '0;
      state_r.op_point   <= '0;
      state_r.alarm_prev <= 1'b1;
      state_r.slow_cnt   <= '0;
      state_r.duty       <= '0; // RL17
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign s_axi_awready = state_r.awready;
  assign s_axi_wready  = state_r.wready;
  assign s_axi_bvalid  = state_r.bvalid;
  assign s_axi_bresp   = state_r.bresp;
  assign s_axi_arready = state_r.arready;
  assign s_axi_rvalid  = state_r.rvalid;
  assign s_axi_rresp   = state_r.rresp;
  assign s_axi_rdata   = state_r.rdata;
  assign duty_out_1    = state_r.duty[0]; // RL12
  assign duty_out_2    = state_r.duty[1];
  assign duty_out_3    = state_r.duty[2];
  assign duty_out_4    = state_r.duty[3];

endmodule

// >>> verification/fdrl_fan.sv
`timescale 1ns/1ps
module fdrl_fan (
  input  wire logic       clk,
  input  wire logic [7:0] duty,
  output logic      [7:0] speed
);
  // rotor follows commanded duty one cycle late
  always_ff @(posedge clk) speed <= duty;
endmodule

// >>> verification/fdrl_chk.sv
`timescale 1ns/1ps
module fdrl_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       duty_update,
  input wire logic [7:0] target_duty_1,
  input wire logic [7:0] duty_out_1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_hold;
    !(ce && duty_update) |=> $stable(duty_out_1);
  endproperty
  a_hold: assert property (p_hold) else $error("duty moved without update");
  property p_up;
    ce && duty_update && target_duty_1 >= duty_out_1
      |=> duty_out_1 <= $past(target_duty_1) && duty_out_1 >= $past(duty_out_1);
  endproperty
  a_up: assert property (p_up) else $error("rising duty overshoot");
  property p_down;
    ce && duty_update && target_duty_1 <= duty_out_1
      |=> duty_out_1 >= $past(target_duty_1) && duty_out_1 <= $past(duty_out_1);
  endproperty
  a_down: assert property (p_down) else $error("falling duty overshoot");
  property p_wlat;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write response late");
  property p_rlat;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read response late");
  property p_bdone;
    ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response not retired");
  property p_rdone;
    ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read response not retired");
  property p_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken while response pending");
  property p_freeze;
    !ce |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid) && $stable(s_axi_awready);
  endproperty
  a_freeze: assert property (p_freeze) else $error("bus state moved while clock enable low");
endmodule
bind fdrl_top fdrl_chk u_chk (.clk, .rst_b, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .duty_update, .target_duty_1, .duty_out_1);

// >>> verification/test_fan_duty_ramp_limiter.sv
`timescale 1ns/1ps
module test_fan_duty_ramp_limiter;
  import fdrl_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, duty_update = 1'b0, thermal_alarm_n = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fan_speed;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] tgt [4] = '{default: 8'h00};
  logic [7:0] temp [4] = '{default: 8'h00};
  logic [7:0] duty [4];
  int n_errors = 0, n_tests = 0;
  localparam logic [7:0] step_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
  always #25 clk = ~clk;
  fdrl_top uut (.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .thermal_alarm_n, .duty_update, .remote_temp_1(temp[0]),
    .remote_temp_2(temp[1]), .remote_temp_3(temp[2]), .remote_temp_4(temp[3]),
    .target_duty_1(tgt[0]), .target_duty_2(tgt[1]), .target_duty_3(tgt[2]),
    .target_duty_4(tgt[3]), .duty_out_1(duty[0]), .duty_out_2(duty[1]),
    .duty_out_3(duty[2]), .duty_out_4(duty[3]));
  fdrl_fan fan1 (.clk, .duty(duty[0]), .speed(fan_speed));
  task automatic chk(input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] st, input logic [1:0] er);
    @(posedge clk);
    {s_axi_awaddr, s_axi_araddr} <= {idx, 2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{~w}};
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (w) chk({1'b1, er}, {s_axi_bvalid, s_axi_bresp});
    else chk({1'b1, er, 24'h000000, d}, {s_axi_rvalid, s_axi_rresp, s_axi_rdata});
  endtask
  task automatic upd(input int n, input logic [31:0] e);
    repeat (n) begin
      @(posedge clk);
      duty_update <= 1'b1;
      @(posedge clk);
      duty_update <= 1'b0;
    end
    @(posedge clk);
    chk(e, {duty[0], duty[1], duty[2], duty[3]});
  endtask
  task automatic t_regs();
    chk(32'h00000000, {duty[0], duty[1], duty[2], duty[3]});
    bus(0, FDRL_IDX_DYN_CTRL, 8'h00, 4'h0, 2'h0);
    bus(0, FDRL_IDX_AC12, 8'h00, 4'h0, 2'h0);
    bus(0, FDRL_IDX_AC34, 8'h00, 4'h0, 2'h0);
    bus(1, FDRL_IDX_AC34, 8'h5A, 4'h1, 2'h0);
    bus(1, FDRL_IDX_AC34, 8'hC3, 4'hE, 2'h0);
    bus(0, FDRL_IDX_AC34, 8'h5A, 4'h0, 2'h0);
    bus(1, 6'h3F, 8'hFF, 4'h1, 2'h2);
    bus(0, 6'h3F, 8'h00, 4'h0, 2'h2);
  endtask
  task automatic t_steps();
    logic [2:0] a;
    for (int c = 0; c < 8; c++) begin
      a = 3'(c);
      bus(1, FDRL_IDX_AC12, 8'h00, 4'h1, 2'h0);
      bus(1, FDRL_IDX_AC34, 8'h00, 4'h1, 2'h0);
      tgt <= '{default: 8'h00};
      upd(1, 32'h00000000);
      bus(1, FDRL_IDX_AC12, {~a, a, 2'h3}, 4'h1, 2'h0);
      bus(1, FDRL_IDX_AC34, {a, ~a, 2'h3}, 4'h1, 2'h0);
      tgt <= '{default: 8'hFF};
      upd(1, {step_tab[a], step_tab[~a], step_tab[~a], step_tab[a]});
    end
  endtask
  task automatic t_ramp();
    bus(1, FDRL_IDX_AC12, 8'h00, 4'h1, 2'h0);
    bus(1, FDRL_IDX_AC34, 8'h00, 4'h1, 2'h0);
    tgt <= '{8'h00, 8'hFF, 8'h00, 8'h2A};
    upd(1, 32'h00FF002A);
    bus(1, FDRL_IDX_AC12, 8'h11, 4'h1, 2'h0);
    tgt <= '{8'h64, 8'h00, 8'h00, 8'h2A};
    for (int i = 1; i < 13; i++) upd(1, {8'(8 * i), 24'h00002A});
    upd(2, 32'h6400002A);
    tgt <= '{8'h5A, 8'h00, 8'h00, 8'h2A};
    upd(1, 32'h5C00002A);
    upd(1, 32'h5A00002A);
    chk(8'h5C, fan_speed);
    bus(1, FDRL_IDX_OUT_CFG1, 8'h08, 4'h1, 2'h0);
    bus(1, FDRL_IDX_AC12, 8'h01, 4'h1, 2'h0);
    tgt <= '{8'hFF, 8'h00, 8'h00, 8'h2A};
    upd(8, 32'h5C00002A);
  endtask
  task automatic t_alarm();
    for (int k = 0; k < 4; k++) bus(1, 6'(FDRL_IDX_OP_PT1 + k), 8'(8'h10 + k), 4'h1, 2'h0);
    temp <= '{8'h80, 8'h81, 8'h82, 8'h83};
    bus(1, FDRL_IDX_DYN_CTRL, 8'h14, 4'h1, 2'h0);
    thermal_alarm_n <= 1'b0;
    repeat (3) @(posedge clk);
    temp <= '{8'h90, 8'h91, 8'h92, 8'h93};
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      bus(0, 6'(FDRL_IDX_OP_PT1 + k), 8'((k[0] ? 8'h10 : 8'h80) + k), 4'h0, 2'h0);
    end
    thermal_alarm_n <= 1'b1;
  endtask
  task automatic t_ce();
    bus(1, FDRL_IDX_AC12, 8'h00, 4'h1, 2'h0);
    tgt <= '{default: 8'h77};
    ce <= 1'b0;
    upd(2, 32'h5C00002A);
    ce <= 1'b1;
    upd(1, 32'h77777777);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_steps();
    t_ramp();
    t_alarm();
    t_ce();
    give_verdict();
  end
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
endmodule
